/* rtl/acpc_clk_gen.sv */
`timescale 1ns/100ps
module acpc_clk_gen
   import acpc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // settings
   input acpc_src_e clockSourceSelect,
   input acpc_div_e clockDivideSelect,
   // candidate sources, sampled on ref_clk
   input wire logic alternateClock,
   input wire logic internalAsyncClock,
   // converter clock as one tick per period
   output logic converterClockTick
);
   localparam logic [2:0] ACPC_CNT_ZERO = 3'h0;
   localparam logic [2:0] ACPC_CNT_ONE = 3'h1;

   // terminal count for divide by 1, 2, 4 or 8
   function automatic logic [2:0] divLimit(input acpc_div_e d);
      logic [2:0] lim;
      lim = 3'h0;
      case (d)
         ACPC_DIV_1: lim = 3'h0;
         ACPC_DIV_2: lim = 3'h1;
         ACPC_DIV_4: lim = 3'h3;
         ACPC_DIV_8: lim = 3'h7;
         default: lim = 3'h0;
      endcase
      return lim;
   endfunction : divLimit

   logic halfPhase_r;
   logic altPrev_r;
   logic asyncPrev_r;
   logic [2:0] divCnt_r;
   logic [2:0] divCnt_nxt;
   logic converterClockTick_r;
   logic srcTick;
   logic divWrap;

   // rising edges of the slower sources become single-cycle ticks
   assign srcTick = (clockSourceSelect == ACPC_SRC_BUS) ? 1'b1 : //RULE_03
                    (clockSourceSelect == ACPC_SRC_BUS_HALF) ? halfPhase_r :
                    (clockSourceSelect == ACPC_SRC_ALT) ? (alternateClock & ~altPrev_r) :
                    (internalAsyncClock & ~asyncPrev_r);
   // a divider lowered below the count wraps on the next source tick rather than running on
   assign divWrap = srcTick && (divCnt_r >= divLimit(clockDivideSelect)); //RULE_01
   assign divCnt_nxt = divWrap ? ACPC_CNT_ZERO :
                       srcTick ? divCnt_r + ACPC_CNT_ONE : divCnt_r;
   assign converterClockTick = converterClockTick_r;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         halfPhase_r <= 1'b0;
         altPrev_r <= 1'b0;
         asyncPrev_r <= 1'b0;
         divCnt_r <= ACPC_CNT_ZERO;
         converterClockTick_r <= 1'b0;
      end else begin
         halfPhase_r <= ~halfPhase_r;
         altPrev_r <= alternateClock;
         asyncPrev_r <= internalAsyncClock;
         divCnt_r <= divCnt_nxt;
         converterClockTick_r <= divWrap;
      end
   end
endmodule : acpc_clk_gen

/* rtl/acpc_pkg.sv */
package acpc_pkg;
   // register byte addresses on the register bus
   localparam logic [3:0] ACPC_OFS_CONFIG = 4'h0;
   localparam logic [3:0] ACPC_OFS_PIN_LOW = 4'h4;
   localparam logic [3:0] ACPC_OFS_PIN_MID = 4'h8;
   localparam int ACPC_ADDR_W = 4;
   localparam int ACPC_REG_W = 8;
   localparam int ACPC_PIN_GROUP = 8;
   localparam int ACPC_PINS = 16;

   // reset values
   localparam logic [7:0] ACPC_RST_CONFIG = 8'h00;
   localparam logic [7:0] ACPC_RST_PIN = 8'h00;

   // field positions inside conversion_config
   localparam int ACPC_BIT_LOW_POWER = 7;
   localparam int ACPC_BIT_DIV_HI = 6;
   localparam int ACPC_BIT_DIV_LO = 5;
   localparam int ACPC_BIT_LONG_SAMPLE = 4;
   localparam int ACPC_BIT_MODE_HI = 3;
   localparam int ACPC_BIT_MODE_LO = 2;
   localparam int ACPC_BIT_SRC_HI = 1;
   localparam int ACPC_BIT_SRC_LO = 0;

   // AXI response codes
   localparam logic [1:0] ACPC_RESP_OKAY = 2'h0;
   localparam logic [1:0] ACPC_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ACPC_RES_8 = 2'b00,
      ACPC_RES_12 = 2'b01,
      ACPC_RES_10 = 2'b10,
      ACPC_RES_RSVD = 2'b11
   } acpc_res_e;

   typedef enum logic [1:0] {
      ACPC_SRC_BUS = 2'b00,
      ACPC_SRC_BUS_HALF = 2'b01,
      ACPC_SRC_ALT = 2'b10,
      ACPC_SRC_ASYNC = 2'b11
   } acpc_src_e;

   typedef enum logic [1:0] {
      ACPC_DIV_1 = 2'b00,
      ACPC_DIV_2 = 2'b01,
      ACPC_DIV_4 = 2'b10,
      ACPC_DIV_8 = 2'b11
   } acpc_div_e;

   // laid out exactly as the config register bits 7..0
   typedef struct packed {
      logic lowPowerSelect;
      acpc_div_e clockDivideSelect;
      logic longSampleSelect;
      acpc_res_e resolutionMode;
      acpc_src_e clockSourceSelect;
   } acpc_cfg_s;

   // one analog-capable pin as seen by the port buffers
   typedef struct packed {
      logic outData;
      logic outEnable;
      logic pullEnable;
      logic inputEnable;
   } acpc_pad_s;
endpackage : acpc_pkg

/* rtl/acpc_top.sv */
`timescale 1ns/100ps
// Functional notes
// RULE_01: config bits 6:5 divide the chosen source by 1, 2, 4 or 8.
// RULE_02: config bits 3:2 pick 8, 12 or 10 bit width; 11 is reserved.
// RULE_03: config bits 1:0 pick bus, bus halved, alternate or internal clock.
// RULE_04: config bit 7 set selects low-power, cleared selects high-speed.
// RULE_05: config bit 4 set selects long sample time, cleared selects short.
// RULE_06: low pin register bit n governs analog channel n, channels 0 to 7.
// RULE_07: mid pin register bit n governs analog channel n plus eight.
// RULE_08: pin bit 0 keeps port control; 1 hands the pin to analog.
// RULE_09: analog pin: output tristated, input reads zero, pullup off.
// RULE_10: after reset the converter clock source is the bus clock.
// RULE_11: all three registers are read/write and clear to zero at reset.
module acpc_top
   import acpc_pkg::*;
#(
   parameter int PINS = ACPC_PINS
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // AXI4-Lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ACPC_ADDR_W-1:0] s_axi_awaddr,
   // AXI4-Lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ACPC_ADDR_W-1:0] s_axi_araddr,
   // AXI4-Lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // converter core settings
   output acpc_cfg_s convCfg,
   output logic resolutionReserved,
   // clock sources and converter clock
   input wire logic alternateClock,
   input wire logic internalAsyncClock,
   output logic converterClockTick,
   // port logic requests per pin
   input wire logic [PINS-1:0] portOutData,
   input wire logic [PINS-1:0] portOutEnable,
   input wire logic [PINS-1:0] portPullEnable,
   // pin pads
   input wire logic [PINS-1:0] padInData,
   output acpc_pad_s [PINS-1:0] padCtrl,
   // port read path and analog selection
   output logic [PINS-1:0] portReadData,
   output logic [PINS-1:0] pinAnalogSelect
);
   ////////////////////////////////////////////////////////////////////////////
   // register select decode, shared by read and write paths
   typedef enum logic [1:0] {
      ACPC_SEL_NONE = 2'b00,
      ACPC_SEL_CONFIG = 2'b01,
      ACPC_SEL_LOW = 2'b10,
      ACPC_SEL_MID = 2'b11
   } acpc_sel_e;

   function automatic acpc_sel_e regSelect(input logic [ACPC_ADDR_W-1:0] a);
      acpc_sel_e s;
      s = ACPC_SEL_NONE;
      case (a)
         ACPC_OFS_CONFIG: s = ACPC_SEL_CONFIG;
         ACPC_OFS_PIN_LOW: s = ACPC_SEL_LOW;
         ACPC_OFS_PIN_MID: s = ACPC_SEL_MID;
         default: s = ACPC_SEL_NONE;
      endcase
      return s;
   endfunction : regSelect

   logic [ACPC_REG_W-1:0] convConfig_r;
   logic [ACPC_REG_W-1:0] pinCtrlLow_r;
   logic [ACPC_REG_W-1:0] pinCtrlMid_r;

   ////////////////////////////////////////////////////////////////////////////
   // write channel: address and data may arrive in either order
   logic awHeld_r;
   logic wHeld_r;
   logic [ACPC_ADDR_W-1:0] awAddr_r;
   logic [7:0] wByte_r;
   logic wLaneOn_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic awFire;
   logic wFire;
   logic haveAw;
   logic haveW;
   logic doWrite;
   logic [ACPC_ADDR_W-1:0] wrAddr;
   logic [7:0] wrByte;
   logic wrLaneOn;
   acpc_sel_e wrSel;

   assign s_axi_awready = !awHeld_r && !bvalid_r;
   assign s_axi_wready = !wHeld_r && !bvalid_r;
   assign awFire = s_axi_awvalid && s_axi_awready;
   assign wFire = s_axi_wvalid && s_axi_wready;
   assign haveAw = awHeld_r || awFire;
   assign haveW = wHeld_r || wFire;
   assign doWrite = haveAw && haveW;
   assign wrAddr = awHeld_r ? awAddr_r : s_axi_awaddr;
   assign wrByte = wHeld_r ? wByte_r : s_axi_wdata[7:0];
   assign wrLaneOn = wHeld_r ? wLaneOn_r : s_axi_wstrb[0];
   assign wrSel = regSelect(wrAddr);
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= '0;
         wByte_r <= 8'h00;
         wLaneOn_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= ACPC_RESP_OKAY;
      end else begin
         if (awFire) begin
            awAddr_r <= s_axi_awaddr;
         end
         if (wFire) begin
            wByte_r <= s_axi_wdata[7:0];
            wLaneOn_r <= s_axi_wstrb[0];
         end
         awHeld_r <= doWrite ? 1'b0 : haveAw;
         wHeld_r <= doWrite ? 1'b0 : haveW;
         if (doWrite) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wrSel == ACPC_SEL_NONE) ? ACPC_RESP_SLVERR : ACPC_RESP_OKAY;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers; only byte lane 0 carries data, upper lanes are ignored
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         convConfig_r <= ACPC_RST_CONFIG; //RULE_10 RULE_11
         pinCtrlLow_r <= ACPC_RST_PIN; //RULE_11
         pinCtrlMid_r <= ACPC_RST_PIN; //RULE_11
      end else if (doWrite && wrLaneOn) begin
         if (wrSel == ACPC_SEL_CONFIG) begin
            convConfig_r <= wrByte; //RULE_11
         end
         if (wrSel == ACPC_SEL_LOW) begin
            pinCtrlLow_r <= wrByte; //RULE_06
         end
         if (wrSel == ACPC_SEL_MID) begin
            pinCtrlMid_r <= wrByte; //RULE_07
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read channel: one read at a time, data registered
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic arFire;
   acpc_sel_e rdSel;
   logic [ACPC_REG_W-1:0] rdByte;

   assign s_axi_arready = !rvalid_r;
   assign arFire = s_axi_arvalid && s_axi_arready;
   assign rdSel = regSelect(s_axi_araddr);
   assign rdByte = (rdSel == ACPC_SEL_CONFIG) ? convConfig_r : //RULE_11
                   (rdSel == ACPC_SEL_LOW) ? pinCtrlLow_r :
                   (rdSel == ACPC_SEL_MID) ? pinCtrlMid_r : 8'h00;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= ACPC_RESP_OKAY;
      end else if (arFire) begin
         rvalid_r <= 1'b1;
         rdata_r <= {24'h00_0000, rdByte};
         rresp_r <= (rdSel == ACPC_SEL_NONE) ? ACPC_RESP_SLVERR : ACPC_RESP_OKAY;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // settings to the converter core straight from the register flops
   assign convCfg.lowPowerSelect = convConfig_r[ACPC_BIT_LOW_POWER]; //RULE_04
   assign convCfg.longSampleSelect = convConfig_r[ACPC_BIT_LONG_SAMPLE]; //RULE_05
   assign convCfg.clockDivideSelect =
      acpc_div_e'(convConfig_r[ACPC_BIT_DIV_HI:ACPC_BIT_DIV_LO]); //RULE_01
   assign convCfg.resolutionMode =
      acpc_res_e'(convConfig_r[ACPC_BIT_MODE_HI:ACPC_BIT_MODE_LO]); //RULE_02
   assign convCfg.clockSourceSelect =
      acpc_src_e'(convConfig_r[ACPC_BIT_SRC_HI:ACPC_BIT_SRC_LO]); //RULE_03
   // reserved width is flagged, the core decides what to do with it
   assign resolutionReserved = (convCfg.resolutionMode == ACPC_RES_RSVD); //RULE_02

   acpc_clk_gen u_clk_gen (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clockSourceSelect(convCfg.clockSourceSelect),
      .clockDivideSelect(convCfg.clockDivideSelect),
      .alternateClock(alternateClock),
      .internalAsyncClock(internalAsyncClock),
      .converterClockTick(converterClockTick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // pin control; pad outputs registered, so port paths lag one cycle
   logic [PINS-1:0] analogSel;
   acpc_pad_s [PINS-1:0] padCtrl_r;
   acpc_pad_s [PINS-1:0] padCtrl_nxt;
   logic [PINS-1:0] portReadData_r;

   assign analogSel = {pinCtrlMid_r, pinCtrlLow_r}; //RULE_06 RULE_07
   assign pinAnalogSelect = analogSel;

   genvar gi;
   generate
      for (gi = 0; gi < PINS; gi++) begin : g_pin
         assign padCtrl_nxt[gi].outData = portOutData[gi] & ~analogSel[gi]; //RULE_08
         assign padCtrl_nxt[gi].outEnable = portOutEnable[gi] & ~analogSel[gi]; //RULE_09
         assign padCtrl_nxt[gi].pullEnable = portPullEnable[gi] & ~analogSel[gi]; //RULE_09
         assign padCtrl_nxt[gi].inputEnable = ~analogSel[gi]; //RULE_09
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         padCtrl_r <= '0;
         portReadData_r <= '0;
      end else begin
         padCtrl_r <= padCtrl_nxt;
         portReadData_r <= padInData & ~analogSel; //RULE_09
      end
   end

   assign padCtrl = padCtrl_r;
   assign portReadData = portReadData_r;
endmodule : acpc_top

/* tb/acpc_partner.sv */
`timescale 1ns/100ps
module acpc_partner #(
   parameter int ALT_HALF = 3,
   parameter int ASYNC_HALF = 5
) (
   input wire logic ref_clk,
   output logic alternateClock,
   output logic internalAsyncClock,
   output logic [15:0] portOutData,
   output logic [15:0] portOutEnable,
   output logic [15:0] portPullEnable,
   output logic [15:0] padInData
);
   int altCnt_r = 0;
   int asyCnt_r = 0;
   // one process owns each clock level, so no second driver at time zero
   logic altPhase_r = 1'b0;
   logic asyPhase_r = 1'b0;
   // pads move every cycle so a stale sample never matches
   logic [15:0] lfsr_r = 16'hACE1;
   always @(posedge ref_clk) begin
      altCnt_r <= (altCnt_r == ALT_HALF - 1) ? 0 : altCnt_r + 1;
      asyCnt_r <= (asyCnt_r == ASYNC_HALF - 1) ? 0 : asyCnt_r + 1;
      if (altCnt_r == ALT_HALF - 1) altPhase_r <= ~altPhase_r;
      if (asyCnt_r == ASYNC_HALF - 1) asyPhase_r <= ~asyPhase_r;
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
   end
   assign alternateClock = altPhase_r;
   assign internalAsyncClock = asyPhase_r;
   assign padInData = lfsr_r;
   assign portOutData = {lfsr_r[7:0], lfsr_r[15:8]};
   assign portOutEnable = ~lfsr_r;
   assign portPullEnable = lfsr_r ^ {lfsr_r[0], lfsr_r[15:1]};
endmodule : acpc_partner

/* tb/acpc_top_sva.sv */
`timescale 1ns/100ps
module acpc_top_sva
   import acpc_pkg::*;
#(
   parameter int PINS = ACPC_PINS
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // bus
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // converter
   input acpc_cfg_s convCfg,
   input wire logic resolutionReserved,
   input wire logic converterClockTick,
   // pins
   input wire logic [PINS-1:0] portOutData,
   input wire logic [PINS-1:0] portOutEnable,
   input wire logic [PINS-1:0] portPullEnable,
   input wire logic [PINS-1:0] padInData,
   input acpc_pad_s [PINS-1:0] padCtrl,
   input wire logic [PINS-1:0] portReadData,
   input wire logic [PINS-1:0] pinAnalogSelect
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire busSrc = convCfg.clockSourceSelect == ACPC_SRC_BUS;
   wire busDiv1 = busSrc && convCfg.clockDivideSelect == ACPC_DIV_1;
   wire busDiv8 = busSrc && convCfg.clockDivideSelect == ACPC_DIV_8;
   ///////////////////////////////////////////////////////////
   a_reset_clears:
      assert property (disable iff (1'b0) !rst_n |=> convCfg == '0 && pinAnalogSelect == '0
         && !s_axi_bvalid && !s_axi_rvalid) else $error("reset left state set");
   a_reset_bus:
      assert property (disable iff (1'b0) !rst_n |=> convCfg.clockSourceSelect == ACPC_SRC_BUS)
      else $error("source not bus after reset");
   a_reserved_flag:
      assert property (resolutionReserved == (convCfg.resolutionMode == ACPC_RES_RSVD))
      else $error("reserved flag wrong");
   a_read_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_port_read:
      assert property (rst_n |=> portReadData == ($past(padInData) & ~$past(pinAnalogSelect)))
      else $error("port read data wrong");
   a_tick_div1:
      assert property (busDiv1 [*3] |=> converterClockTick) else $error("bus div1 tick missing");
   a_tick_div8:
      assert property (busDiv8 ##1 converterClockTick && busDiv8 ##1
         (busDiv8 && !converterClockTick) [*7] |=> converterClockTick)
      else $error("div8 period wrong");
   for (genvar i = 0; i < PINS; i++) begin : g_pin
      a_pad_analog:
         assert property (pinAnalogSelect[i] |=> padCtrl[i] == 4'h0)
         else $error("analog pin not isolated");
      a_pad_pass:
         assert property (!pinAnalogSelect[i] |=> padCtrl[i] == {$past(portOutData[i]),
            $past(portOutEnable[i]), $past(portPullEnable[i]), 1'b1})
         else $error("port pin not passed");
   end
endmodule : acpc_top_sva
bind acpc_top acpc_top_sva #(.PINS(PINS)) u_sva (.ref_clk, .rst_n, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .convCfg, .resolutionReserved,
   .converterClockTick, .portOutData, .portOutEnable, .portPullEnable, .padInData,
   .padCtrl, .portReadData, .pinAnalogSelect);

/* tb/test_adc_config_and_pin_control.sv */
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
   begin \
      checkCount++; \
      if ((got) !== (ex)) begin \
         errors++; \
         $display("BAD %s expected %0h seen %0h", nm, ex, got); \
      end \
   end
module test_adc_config_and_pin_control
   import acpc_pkg::*;
;
   localparam logic [15:0] SEL = 16'h3CA5;
   int errors = 0;
   int checkCount = 0;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   acpc_cfg_s convCfg;
   acpc_pad_s [15:0] padCtrl;
   logic resolutionReserved, alternateClock, internalAsyncClock, converterClockTick;
   logic [15:0] portOutData, portOutEnable, portPullEnable, padInData;
   logic [15:0] portReadData, pinAnalogSelect;
   always #2 ref_clk = ~ref_clk;
   acpc_top #(.PINS(16)) dut (.ref_clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
      .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
      .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .convCfg,
      .resolutionReserved, .alternateClock, .internalAsyncClock, .converterClockTick,
      .portOutData, .portOutEnable, .portPullEnable, .padInData, .padCtrl, .portReadData,
      .pinAnalogSelect);
   acpc_partner #(.ALT_HALF(3), .ASYNC_HALF(5)) u_partner (.ref_clk, .alternateClock,
      .internalAsyncClock, .portOutData, .portOutEnable, .portPullEnable, .padInData);
   ///////////////////////////////////////////////////////////
   task automatic axWrite(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s,
         input logic [1:0] er);
      @(posedge ref_clk);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= s;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      `CHK("bresp", er, s_axi_bresp)
   endtask : axWrite
   task automatic axRead(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
      @(posedge ref_clk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      `CHK("rdata", {24'h0, d}, s_axi_rdata)
      `CHK("rresp", er, s_axi_rresp)
   endtask : axRead
   task automatic waitTick(output int n);
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (converterClockTick !== 1'b1);
   endtask : waitTick
   ///////////////////////////////////////////////////////////
   task automatic resetScenario();
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      axRead(ACPC_OFS_CONFIG, 8'h00, ACPC_RESP_OKAY);
      axRead(ACPC_OFS_PIN_LOW, 8'h00, ACPC_RESP_OKAY);
      axRead(ACPC_OFS_PIN_MID, 8'h00, ACPC_RESP_OKAY);
      `CHK("source", ACPC_SRC_BUS, convCfg.clockSourceSelect)
   endtask : resetScenario
   task automatic fieldScenario();
      logic [7:0] v;
      for (int k = 0; k < 4; k++) begin
         v = {k[0], k[1:0], k[1], k[1:0], k[1:0]};
         axWrite(ACPC_OFS_CONFIG, v, 4'h1, ACPC_RESP_OKAY);
         axRead(ACPC_OFS_CONFIG, v, ACPC_RESP_OKAY);
         `CHK("divide", v[6:5], convCfg.clockDivideSelect)
         `CHK("mode", v[3:2], convCfg.resolutionMode)
         `CHK("reserved", 1'(k == 3), resolutionReserved)
         `CHK("source", v[1:0], convCfg.clockSourceSelect)
         `CHK("lowpower", v[7], convCfg.lowPowerSelect)
         `CHK("longsample", v[4], convCfg.longSampleSelect)
      end
   endtask : fieldScenario
   // source s paired with divider s, so all four of each are met
   task automatic clockScenario();
      int per[4];
      int n;
      per = '{1, 2, 6, 10};
      for (int s = 0; s < 4; s++) begin
         axWrite(ACPC_OFS_CONFIG, {1'b0, s[1:0], 3'b000, s[1:0]}, 4'h1, ACPC_RESP_OKAY);
         repeat (3) waitTick(n);
         `CHK("period", per[s] << s, n)
      end
      // bus source with the largest divider walks the whole count
      axWrite(ACPC_OFS_CONFIG, {1'b0, ACPC_DIV_8, 3'b000, ACPC_SRC_BUS}, 4'h1, ACPC_RESP_OKAY);
      repeat (3) waitTick(n);
      `CHK("period", 8, n)
   endtask : clockScenario
   task automatic pinScenario();
      logic [15:0] din, od, oe, pe;
      axWrite(ACPC_OFS_PIN_LOW, 8'hA5, 4'h1, ACPC_RESP_OKAY);
      axWrite(ACPC_OFS_PIN_MID, 8'h3C, 4'h1, ACPC_RESP_OKAY);
      axWrite(ACPC_OFS_PIN_LOW, 8'hFF, 4'h0, ACPC_RESP_OKAY);
      axWrite(4'hC, 8'h5A, 4'h1, ACPC_RESP_SLVERR);
      axRead(4'hC, 8'h00, ACPC_RESP_SLVERR);
      axRead(ACPC_OFS_PIN_LOW, 8'hA5, ACPC_RESP_OKAY);
      axRead(ACPC_OFS_PIN_MID, 8'h3C, ACPC_RESP_OKAY);
      `CHK("select", SEL, pinAnalogSelect)
      repeat (3) begin
         @(negedge ref_clk);
         din = padInData;
         od = portOutData;
         oe = portOutEnable;
         pe = portPullEnable;
         @(negedge ref_clk);
         `CHK("portread", din & ~SEL, portReadData)
         for (int i = 0; i < 16; i++) begin
            `CHK("pad", SEL[i] ? 4'h0 : {od[i], oe[i], pe[i], 1'b1}, padCtrl[i])
         end
      end
   endtask : pinScenario
   task automatic give_verdict();
      if (errors == 0 && checkCount > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      resetScenario();
      fieldScenario();
      clockScenario();
      pinScenario();
      resetScenario();
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      give_verdict();
   end
endmodule : test_adc_config_and_pin_control
